// ===== dv/capture_and_cascade_timer_bench.sv
`timescale 1ns/1ps
`include "capture_cascade_cfg.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_errors++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module capture_and_cascade_timer_bench;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic measured_pulse_pin;
	logic long_pulse_out_pin;
	logic irq;
	logic [31:0] rdv;
	logic errv;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// ****************************************************************
	// Clock, design and partner
	// ****************************************************************
	always #12.5 mclk = ~mclk;
	capture_and_cascade_timer u_dut (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.measured_pulse_pin(measured_pulse_pin),
		.long_pulse_out_pin(long_pulse_out_pin), .irq(irq));
	pulse_partner u_partner (.mclk(mclk), .long_pulse_out_pin(long_pulse_out_pin),
		.measured_pulse_pin(measured_pulse_pin));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// One transfer: setup, access until pready, then release
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	// Verdict and end of run
	task automatic conclude;
		if (n_errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Reset values and an unmapped word
	task automatic t_reset_map;
		apb(1'b0, `OFS_CMP_FIRST, 32'h0);
		`CHK("cmp_first", 32'h0000ffff, rdv)
		apb(1'b0, `OFS_CMP_SECOND, 32'h0);
		`CHK("cmp_second", 32'h0000ffff, rdv)
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK("status", 32'h00000000, rdv)
		apb(1'b1, 8'h3c, 32'h0000005a);
		apb(1'b0, 8'h3c, 32'h0);
		`CHK("unmapped data", 32'h00000000, rdv)
		`CHK("unmapped err", 1'b1, errv)
	endtask
	// Rising capture clears the counter; falling mode measures 200 cycles
	task automatic t_capture;
		apb(1'b1, `OFS_CTL0, 32'h20);
		apb(1'b1, `OFS_IO0, 32'h08);
		apb(1'b1, `OFS_IEN, 32'h41);
		apb(1'b1, `OFS_START, 32'h01);
		u_partner.drive(1'b1);
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge mclk);
		`CHK("irq rise", 1'b1, irq)
		apb(1'b0, `OFS_CNT0, 32'h0);
		`CHK("count cleared", 1'b1, rdv < 32'h8)
		apb(1'b1, `OFS_STATUS, 32'h0);
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b1, `OFS_IO0, 32'h09);
		u_partner.drive(1'b0);
		repeat (9) @(posedge mclk);
		`CHK("irq first fall", 1'b1, irq)
		apb(1'b1, `OFS_STATUS, 32'h0);
		repeat (87) @(posedge mclk);
		u_partner.drive(1'b1);
		repeat (99) @(posedge mclk);
		`CHK("no rise capture", 1'b0, irq)
		u_partner.drive(1'b0);
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge mclk);
		`CHK("irq fall", 1'b1, irq)
		apb(1'b0, `OFS_CAPA, 32'h0);
		`CHK("fall width", 1'b1, rdv >= 32'h63 && rdv <= 32'h65)
		`CHK("width span", 16'h0000, rdv[31:16])
		apb(1'b1, `OFS_IO0, 32'h0a);
		apb(1'b1, `OFS_STATUS, 32'h0);
		`CHK("irq both idle", 1'b0, irq)
		u_partner.drive(1'b1);
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge mclk);
		`CHK("irq both rise", 1'b1, irq)
		apb(1'b1, `OFS_STATUS, 32'h0);
		u_partner.drive(1'b0);
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge mclk);
		`CHK("irq both fall", 1'b1, irq)
	endtask
	// Enable masks the line, write one keeps, write zero clears
	task automatic t_mask_clear;
		apb(1'b1, `OFS_IEN, 32'h00);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, `OFS_IEN, 32'h41);
		`CHK("irq unmasked", 1'b1, irq)
		apb(1'b1, `OFS_STATUS, 32'h01);
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK("status kept", 32'h00000001, rdv)
		apb(1'b1, `OFS_STATUS, 32'h00);
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK("status zero", 32'h00000000, rdv)
		`CHK("irq low", 1'b0, irq)
	endtask
	// Counter wraps to zero with overflow flag, then stops with start clear
	task automatic t_wrap_stop;
		logic [31:0] held;
		apb(1'b1, `OFS_CNT0, 32'hfffe);
		repeat (8) @(posedge mclk);
		apb(1'b0, `OFS_STATUS, 32'h0);
		`CHK("ovf flag", 1'b1, rdv[`BIT_OVF0])
		`CHK("ovf masked", 1'b0, irq)
		apb(1'b0, `OFS_CNT0, 32'h0);
		`CHK("wrapped", 1'b1, rdv < 32'h10)
		apb(1'b1, `OFS_START, 32'h00);
		apb(1'b0, `OFS_CNT0, 32'h0);
		held = rdv;
		repeat (20) @(posedge mclk);
		apb(1'b0, `OFS_CNT0, 32'h0);
		`CHK("stopped", held, rdv)
	endtask
	// Cascade: upper steps per lower wrap, PWM pair sets and clears the pin
	task automatic t_cascade_pwm;
		apb(1'b1, `OFS_CTL1, 32'h47);
		apb(1'b1, `OFS_MODE1, 32'h02);
		apb(1'b1, `OFS_IO1, 32'h12);
		apb(1'b1, `OFS_CMP_FIRST, 32'h0000);
		apb(1'b1, `OFS_CMP_SECOND, 32'h0001);
		apb(1'b1, `OFS_CNT_UPPER, 32'h0);
		apb(1'b1, `OFS_CNT_LOWER, 32'hfff0);
		apb(1'b1, `OFS_START, 32'h06);
		apb(1'b0, `OFS_CNT_UPPER, 32'h0);
		`CHK("upper idle", 32'h00000000, rdv)
		`CHK("pin low", 1'b0, long_pulse_out_pin)
		for (int i = 0; i < 60 && long_pulse_out_pin !== 1'b1; i++) @(posedge mclk);
		`CHK("pin high", 1'b1, long_pulse_out_pin)
		apb(1'b0, `OFS_CNT_UPPER, 32'h0);
		`CHK("upper step", 32'h00000001, rdv)
		apb(1'b0, `OFS_CNT_LOWER, 32'h0);
		`CHK("lower runs", 1'b1, rdv < 32'h20)
		apb(1'b1, `OFS_CNT_LOWER, 32'hfff0);
		for (int i = 0; i < 60 && long_pulse_out_pin !== 1'b0; i++) @(posedge mclk);
		`CHK("pin low again", 1'b0, long_pulse_out_pin)
		apb(1'b0, `OFS_CNT_UPPER, 32'h0);
		`CHK("cycle restart", 32'h00000000, rdv)
		`CHK("load edges", 2, u_partner.out_edges)
	endtask
	// ****************************************************************
	// Main sequence and hang guard
	// ****************************************************************
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude;
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		t_reset_map();
		t_capture();
		t_mask_clear();
		t_wrap_stop();
		t_cascade_pwm();
		conclude();
	end
endmodule // capture_and_cascade_timer_bench

// ===== dv/pulse_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// Pulse source on the measured pin, load on the output pin
// ****************************************************************
module pulse_partner (
	input wire logic mclk,
	input wire logic long_pulse_out_pin,
	output logic measured_pulse_pin
);
	int out_edges;
	logic last_out;
	// Source starts low, load has seen no edge yet
	initial begin
		measured_pulse_pin = 1'b0;
		out_edges = 0;
		last_out = 1'b0;
	end
	// Move the source level just after a rising edge
	task automatic drive(input logic lvl);
		@(posedge mclk);
		measured_pulse_pin <= lvl;
	endtask
	// Load counts every level change of the output
	always @(posedge mclk) begin
		if (long_pulse_out_pin != last_out) begin
			out_edges++;
		end
		last_out <= long_pulse_out_pin;
	end
endmodule // pulse_partner

// ===== src/capture_and_cascade_timer.sv
`timescale 1ns/1ps
`include "capture_cascade_cfg.svh"
// How it works
// R1 - On the chosen edge of the measured pin the channel zero count is copied into capture register A.
// R2 - With capture A chosen as clear source in the counter control, each capture A zeroes the count.
// R3 - Captures on rising or on falling edges can each raise an interrupt request.
// R4 - The capture A request reaches the interrupt line only while its enable bit is set.
// R5 - Each capture A sets a status flag that software clears by writing zero to it.
// R6 - Edge control value 0x08 captures on rising edges and 0x09 on falling edges.
// R7 - Counting advances once per 50 ns, so a full 16-bit span is about 3.27 ms.
// R8 - Each counter runs only while its bit in the shared start register is set.
// R9 - Channels one and two can be linked to behave as one 32-bit counter.
// R10 - In cascade the upper counter steps once per overflow of the lower counter.
// R11 - The lower counter free-runs as the low 16 bits, channel one holds the high 16 bits.
// R12 - Compare matches change the output pin level with no software action.
// R13 - In the first PWM mode the first and second compare registers each set one output edge.
// R14 - The cascaded output reaches any duty from 0% to 100% at 1/65,536 steps.
// R15 - The cascaded output cycle is set in whole lower-counter wraps from 3.28 ms to 214.7 s.
// R16 - Each counter steps by one per enabled tick and wraps from all ones to zero with overflow.
// R17 - Each capture overwrites capture register A whether or not it was read.
module capture_and_cascade_timer (
	input wire logic mclk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic measured_pulse_pin,
	output logic long_pulse_out_pin,
	output logic irq
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] counter_start_reg;
	capture_cascade_pkg::channel_cfg_type ch0;
	capture_cascade_pkg::channel_cfg_type ch1;
	capture_cascade_pkg::channel_cfg_type ch2;
	// Channel fields kept as separate flops, each written by one process only
	logic [7:0] ctl0;
	logic [7:0] io0;
	logic [15:0] count0;
	logic [7:0] ctl1;
	logic [7:0] io1;
	logic [7:0] ctl2;
	logic [7:0] interrupt_enable_reg;
	logic [7:0] timer_status_reg;
	logic [15:0] capture_compare_reg_a;
	logic [7:0] channel_mode_reg;
	logic [15:0] pair_compare_first;
	logic [15:0] pair_compare_second;
	logic [15:0] lower_half_counter;
	logic [15:0] upper_half_counter;
	logic [1:0] tick_count;
	logic tick_base;
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	logic capture_evt;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic [7:0] next_status;
	logic [7:0] status_set;
	logic [7:0] status_clr;
	logic tick0;
	logic tick1;
	logic tick2;
	logic ovf0;
	logic ovf1;
	logic ovf2;
	logic cascade;
	logic pwm_mode;
	logic clear_second;
	capture_cascade_pkg::match_type match;
	capture_cascade_pkg::edge_sel_type edge_sel;

	// Bus strobes
	assign wr_en = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Channel views for readers; channel two has no edge control of its own
	assign ch0 = {ctl0, io0, count0};
	assign ch1 = {ctl1, io1, upper_half_counter};
	assign ch2 = {ctl2, 8'h00, lower_half_counter};

	// ****************************************************************
	// Address decode and read data
	// ****************************************************************
	always_comb begin
		unique case (paddr)
			`OFS_START, `OFS_CTL0, `OFS_IO0, `OFS_IEN, `OFS_STATUS, `OFS_CAPA,
			`OFS_CNT0, `OFS_MODE1, `OFS_CTL1, `OFS_IO1, `OFS_CMP_FIRST,
			`OFS_CMP_SECOND, `OFS_CNT_UPPER, `OFS_CTL2, `OFS_CNT_LOWER: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Read data registered in the setup phase
	always_ff @(posedge mclk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (paddr)
				`OFS_START: prdata <= {24'h00_0000, counter_start_reg};
				`OFS_CTL0: prdata <= {24'h00_0000, ch0.ctl};
				`OFS_IO0: prdata <= {24'h00_0000, ch0.io};
				`OFS_IEN: prdata <= {24'h00_0000, interrupt_enable_reg};
				`OFS_STATUS: prdata <= {24'h00_0000, timer_status_reg};
				`OFS_CAPA: prdata <= {16'h0000, capture_compare_reg_a};
				`OFS_CNT0: prdata <= {16'h0000, ch0.count};
				`OFS_MODE1: prdata <= {24'h00_0000, channel_mode_reg};
				`OFS_CTL1: prdata <= {24'h00_0000, ch1.ctl};
				`OFS_IO1: prdata <= {24'h00_0000, ch1.io};
				`OFS_CMP_FIRST: prdata <= {16'h0000, pair_compare_first};
				`OFS_CMP_SECOND: prdata <= {16'h0000, pair_compare_second};
				`OFS_CNT_UPPER: prdata <= {16'h0000, upper_half_counter};
				`OFS_CTL2: prdata <= {24'h00_0000, ch2.ctl};
				`OFS_CNT_LOWER: prdata <= {16'h0000, lower_half_counter};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			counter_start_reg <= 8'h00;
			ctl0 <= 8'h00;
			io0 <= 8'h00;
			ctl1 <= 8'h00;
			io1 <= 8'h00;
			ctl2 <= 8'h00;
			interrupt_enable_reg <= 8'h00;
			channel_mode_reg <= 8'h00;
			pair_compare_first <= `CNT_ALL_ONES;
			pair_compare_second <= `CNT_ALL_ONES;
		end else if (wr_en) begin
			unique case (paddr)
				`OFS_START: counter_start_reg <= pwdata[7:0] & `START_MASK; // R8
				`OFS_CTL0: ctl0 <= pwdata[7:0];
				`OFS_IO0: io0 <= pwdata[7:0];
				`OFS_IEN: interrupt_enable_reg <= pwdata[7:0] & `IEN_MASK;
				`OFS_MODE1: channel_mode_reg <= pwdata[7:0];
				`OFS_CTL1: ctl1 <= pwdata[7:0];
				`OFS_IO1: io1 <= pwdata[7:0];
				`OFS_CMP_FIRST: pair_compare_first <= pwdata[15:0];
				`OFS_CMP_SECOND: pair_compare_second <= pwdata[15:0];
				`OFS_CTL2: ctl2 <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Count tick at 50 ns
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (srst) begin
			tick_count <= 2'h0;
		end else if (tick_base) begin
			tick_count <= 2'h0;
		end else begin
			tick_count <= tick_count + 2'h1; // R7
		end
	end
	assign tick_base = (tick_count == 2'(`TICK_CYCLES - 1)); // R7

	// ****************************************************************
	// Input capture on channel zero
	// ****************************************************************
	// Pin synchroniser plus an edge history stage
	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= measured_pulse_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Edge selection: bit 3 enables capture, low bits choose the edge
	always_comb begin
		unique case (ch0.io[1:0])
			2'h0: edge_sel = capture_cascade_pkg::edge_rise;
			2'h1: edge_sel = capture_cascade_pkg::edge_fall;
			default: edge_sel = capture_cascade_pkg::edge_both;
		endcase
	end
	always_comb begin
		unique case (edge_sel)
			capture_cascade_pkg::edge_rise: capture_evt = ch0.io[3] & pin_sync & ~pin_prev; // R6
			capture_cascade_pkg::edge_fall: capture_evt = ch0.io[3] & ~pin_sync & pin_prev; // R6
			capture_cascade_pkg::edge_both: capture_evt = ch0.io[3] & (pin_sync ^ pin_prev); // R3
		endcase
	end

	// Capture register, overwritten on every capture
	always_ff @(posedge mclk) begin
		if (srst) begin
			capture_compare_reg_a <= `CNT_ZERO;
		end else if (capture_evt) begin
			capture_compare_reg_a <= ch0.count; // R1 R17
		end else if (wr_en && paddr == `OFS_CAPA) begin
			capture_compare_reg_a <= pwdata[15:0];
		end
	end

	// Channel zero counter
	assign tick0 = tick_base & counter_start_reg[0]; // R8
	assign ovf0 = tick0 & (ch0.count == `CNT_ALL_ONES); // R16
	always_ff @(posedge mclk) begin
		if (srst) begin
			count0 <= `CNT_ZERO;
		end else if (wr_en && paddr == `OFS_CNT0) begin
			count0 <= pwdata[15:0];
		end else if (capture_evt && ctl0[7:5] == `CLR_SRC_CAPA) begin
			count0 <= `CNT_ZERO; // R2
		end else if (tick0) begin
			count0 <= count0 + `CNT_ONE; // R16
		end
	end

	// ****************************************************************
	// Cascaded pair: channel two low half, channel one high half
	// ****************************************************************
	assign tick2 = tick_base & counter_start_reg[2]; // R11
	assign ovf2 = tick2 & (ch2.count == `CNT_ALL_ONES); // R16
	assign cascade = (ch1.ctl[2:0] == `CLK_SEL_CASCADE); // R9
	assign tick1 = counter_start_reg[1] & (cascade ? ovf2 : tick_base); // R10
	assign ovf1 = tick1 & (ch1.count == `CNT_ALL_ONES);
	assign pwm_mode = (channel_mode_reg[3:0] == `MODE_PWM1);
	assign match.first = tick1 & (ch1.count == pair_compare_first);
	assign match.second = tick1 & (ch1.count == pair_compare_second);
	assign clear_second = match.second & (ch1.ctl[7:5] == `CLR_SRC_CMPB); // R15

	// Lower half free-runs
	always_ff @(posedge mclk) begin
		if (srst) begin
			lower_half_counter <= `CNT_ZERO;
		end else if (wr_en && paddr == `OFS_CNT_LOWER) begin
			lower_half_counter <= pwdata[15:0];
		end else if (tick2) begin
			lower_half_counter <= lower_half_counter + `CNT_ONE; // R11 R16
		end
	end

	// Upper half steps per lower overflow in cascade
	always_ff @(posedge mclk) begin
		if (srst) begin
			upper_half_counter <= `CNT_ZERO;
		end else if (wr_en && paddr == `OFS_CNT_UPPER) begin
			upper_half_counter <= pwdata[15:0];
		end else if (clear_second) begin
			upper_half_counter <= `CNT_ZERO; // R15
		end else if (tick1) begin
			upper_half_counter <= upper_half_counter + `CNT_ONE; // R10
		end
	end

	// Output pin: first match edge, then second match edge in PWM mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			long_pulse_out_pin <= 1'b0;
		end else if (pwm_mode && match.second && ch1.io[5:4] != 2'h0) begin
			long_pulse_out_pin <= ch1.io[5]; // R13 R14
		end else if (match.first && ch1.io[1:0] != 2'h0) begin
			long_pulse_out_pin <= ch1.io[1]; // R12 R13
		end
	end

	// ****************************************************************
	// Status flags and interrupt
	// ****************************************************************
	// Hardware set wins over a write-zero clear
	always_comb begin
		status_set = 8'h00;
		status_set[`BIT_CAPA] = capture_evt; // R5
		status_set[`BIT_OVF0] = ovf0;
		status_set[`BIT_OVF1] = ovf1;
		status_clr = (wr_en && paddr == `OFS_STATUS) ? (~pwdata[7:0] & `STATUS_MASK) : 8'h00;
		next_status = ((timer_status_reg & ~status_clr) | status_set) & `STATUS_MASK; // R5
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			timer_status_reg <= 8'h00;
		end else begin
			timer_status_reg <= next_status;
		end
	end
	assign irq = |(timer_status_reg & interrupt_enable_reg & `STATUS_MASK); // R4

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_capture_copies: assert property (@(posedge mclk) disable iff (srst)
		capture_evt |=> capture_compare_reg_a == $past(ch0.count)) // R1
		else $error("capture register did not take the count");
	a_capture_clears: assert property (@(posedge mclk) disable iff (srst)
		capture_evt && ch0.ctl[7:5] == `CLR_SRC_CAPA && !(wr_en && paddr == `OFS_CNT0)
		|=> ch0.count == `CNT_ZERO) // R2
		else $error("counter not cleared on capture");
	a_flag_sets: assert property (@(posedge mclk) disable iff (srst)
		capture_evt |=> timer_status_reg[`BIT_CAPA]) // R5
		else $error("capture flag not set");
	a_irq_gated: assert property (@(posedge mclk) disable iff (srst)
		capture_evt && interrupt_enable_reg[`BIT_CAPA] && !(wr_en && paddr == `OFS_IEN)
		|=> irq) // R3
		else $error("enabled capture did not raise irq");
	a_irq_masked: assert property (@(posedge mclk) disable iff (srst)
		!interrupt_enable_reg[`BIT_OVF0] && !interrupt_enable_reg[`BIT_OVF1]
		&& !timer_status_reg[`BIT_CAPA] |-> !irq) // R4
		else $error("irq without enabled flag");
	a_edge_select: assert property (@(posedge mclk) disable iff (srst)
		ch0.io == 8'h08 && $rose(pin_sync) |-> capture_evt) // R6
		else $error("rising edge capture missed");
	a_fall_only: assert property (@(posedge mclk) disable iff (srst)
		ch0.io == 8'h09 && capture_evt |-> $fell(pin_sync)) // R6
		else $error("capture on wrong edge");
	a_tick_spacing: assert property (@(posedge mclk) disable iff (srst)
		tick_base |=> !tick_base ##1 tick_base) // R7
		else $error("count tick not every 50 ns");
	a_stop_holds: assert property (@(posedge mclk) disable iff (srst)
		!counter_start_reg[0] && !capture_evt && !wr_en |=> $stable(ch0.count)) // R8
		else $error("stopped counter moved");
	a_upper_holds: assert property (@(posedge mclk) disable iff (srst)
		cascade && !ovf2 && !wr_en |=> $stable(ch1.count)) // R9
		else $error("upper half moved without lower overflow");
	a_cascade_step: assert property (@(posedge mclk) disable iff (srst)
		cascade && ovf2 && counter_start_reg[1] && !clear_second && !wr_en
		|=> ch1.count == $past(ch1.count) + `CNT_ONE) // R10
		else $error("upper half did not step on overflow");
	a_lower_wrap: assert property (@(posedge mclk) disable iff (srst)
		tick2 && ch2.count == `CNT_ALL_ONES && !wr_en |=> ch2.count == `CNT_ZERO) // R16
		else $error("lower half did not wrap");
	a_pwm_edges: assert property (@(posedge mclk) disable iff (srst)
		pwm_mode && match.first && !match.second && ch1.io[1:0] == 2'h2
		|=> long_pulse_out_pin) // R13
		else $error("first match did not raise output");
	a_pwm_second: assert property (@(posedge mclk) disable iff (srst)
		pwm_mode && match.second && ch1.io[5:4] == 2'h1
		|=> !long_pulse_out_pin) // R13
		else $error("second match did not lower output");
	a_upper_clear: assert property (@(posedge mclk) disable iff (srst)
		clear_second && !wr_en |=> ch1.count == `CNT_ZERO) // R15
		else $error("upper half not cleared at cycle end");
	a_both_edges: assert property (@(posedge mclk) disable iff (srst)
		ch0.io == 8'h0a && $changed(pin_sync) |-> capture_evt) // R3
		else $error("both edge capture missed");
	a_counter_step: assert property (@(posedge mclk) disable iff (srst)
		tick0 && ch0.count != `CNT_ALL_ONES && !capture_evt && !wr_en
		|=> ch0.count == $past(ch0.count) + `CNT_ONE) // R16
		else $error("counter did not step by one");
	a_out_holds: assert property (@(posedge mclk) disable iff (srst)
		!match.first && !match.second |=> $stable(long_pulse_out_pin)) // R12
		else $error("output moved without a match");
	a_ovf_flag: assert property (@(posedge mclk) disable iff (srst)
		ovf0 |=> timer_status_reg[`BIT_OVF0]) // R16
		else $error("overflow flag not set");
endmodule // capture_and_cascade_timer

// ===== src/capture_cascade_cfg.svh
`ifndef CAPTURE_CASCADE_CFG_SVH
`define CAPTURE_CASCADE_CFG_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_START 8'h00
`define OFS_CTL0 8'h04
`define OFS_IO0 8'h08
`define OFS_IEN 8'h0c
`define OFS_STATUS 8'h10
`define OFS_CAPA 8'h14
`define OFS_CNT0 8'h18
`define OFS_MODE1 8'h1c
`define OFS_CTL1 8'h20
`define OFS_IO1 8'h24
`define OFS_CMP_FIRST 8'h28
`define OFS_CMP_SECOND 8'h2c
`define OFS_CNT_UPPER 8'h30
`define OFS_CTL2 8'h34
`define OFS_CNT_LOWER 8'h38
// ****************************************************************
// Field values and masks
// ****************************************************************
`define CLR_SRC_CAPA 3'h1
`define CLR_SRC_CMPB 3'h2
`define CLK_SEL_CASCADE 3'h7
`define MODE_PWM1 4'h2
`define IEN_MASK 8'h71
`define STATUS_MASK 8'h31
`define BIT_CAPA 0
`define BIT_OVF0 4
`define BIT_OVF1 5
`define START_MASK 8'h07
`define CNT_ALL_ONES 16'hffff
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
// ****************************************************************
// Timing
// ****************************************************************
`define MCLK_PERIOD_NS 25
`define COUNT_PERIOD_NS 50
`define TICK_CYCLES ((`COUNT_PERIOD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// ===== src/capture_cascade_pkg.sv
package capture_cascade_pkg;
	// ****************************************************************
	// Shared types
	// ****************************************************************
	typedef enum logic [1:0] {edge_rise, edge_fall, edge_both} edge_sel_type;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] io;
		logic [15:0] count;
	} channel_cfg_type;
	typedef struct packed {
		logic first;
		logic second;
	} match_type;
endpackage
